//--- common/eeprom_host_pkg.sv
package eeprom_host_pkg;
	localparam int CLK_PERIOD_NS = 8;
	// shortest scl low time; one quarter of a bit cell is this long so every
	// low, high, setup, hold and bus-free time is met with margin
	localparam int T_LOW_NS = 4700;
	localparam int QUARTER_CYC = (T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int QUARTER_W = 10;
	localparam int WRITE_CYCLE_TIME_MS = 10;
	localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int RECOVER_PULSES = 9;
	localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [1:0] PH_LAST = 2'h3;
	localparam logic SCL_IDLE = 1'b1;
	localparam logic SDA_RELEASED = 1'b1;

	typedef enum logic [1:0] {OP_WRITE, OP_READ_CUR, OP_READ_RAND, OP_RECOVER} op_type;
	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_BYTE, ST_ACK, ST_STOP, ST_RECOVER} state_type;
	typedef enum logic [2:0] {STG_DEV_W, STG_ADDR, STG_WDATA, STG_DEV_R, STG_RDATA, STG_NONE}
		stage_type;
endpackage

//--- common/byte_stream_if.sv
`timescale 1ns/10ps
interface byte_stream_if #(parameter int W = 8);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

//--- hdl/pin_sync2.sv
`timescale 1ns/10ps
module pin_sync2 #(
	parameter int W = 1,
	parameter logic RST_VAL = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_ff <= {W{RST_VAL}};
			sync_ff <= {W{RST_VAL}};
		end else begin
			meta_ff <= d_i;
			sync_ff <= meta_ff;
		end
	end

	assign q_o = sync_ff;
endmodule

//--- hdl/skid_fifo2.sv
`timescale 1ns/10ps
module skid_fifo2 #(
	parameter int W = 8
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	byte_stream_if.snk in_s,
	byte_stream_if.src out_s
);
	logic [1:0] cnt_ff;
	logic [1:0] nxt_cnt;
	logic [W-1:0] tail_ff;
	logic push;
	logic pop;

	assign push = in_s.valid && in_s.ready;
	assign pop = out_s.valid && out_s.ready;

	always_comb begin
		nxt_cnt = 2'(cnt_ff + {1'b0, push} - {1'b0, pop});
	end

	// flags are registered so both sides see plain flip-flops
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_ff <= 2'h0;
			in_s.ready <= 1'b1;
			out_s.valid <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			in_s.ready <= nxt_cnt != 2'h2;
			out_s.valid <= nxt_cnt != 2'h0;
		end
	end

	// head entry drives the output directly; tail only fills behind it
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			out_s.data <= '0;
			tail_ff <= '0;
		end else begin
			if (push && (cnt_ff == 2'h0 || (cnt_ff == 2'h1 && pop))) begin
				out_s.data <= in_s.data;
			end else if (pop && cnt_ff == 2'h2) begin
				out_s.data <= tail_ff;
			end
			if (push && cnt_ff == 2'h1 && !pop) begin
				tail_ff <= in_s.data;
			end
		end
	end
endmodule

//--- hdl/eeprom_host_ctrl.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module eeprom_host_ctrl #(
	parameter int ADDR_W = 11,
	parameter int LEN_W = 4,
	parameter int POLL_LIMIT_CYC = eeprom_host_pkg::WRITE_CYCLE_CYC,
	parameter int QUARTER_LEN = eeprom_host_pkg::QUARTER_CYC
) (
	input wire logic CLK_I,
	input wire logic RST_B_I,
	input wire logic CMD_VALID_I,
	output logic CMD_READY_O,
	input wire logic [1:0] CMD_OP_I,
	input wire logic [ADDR_W-1:0] CMD_ADDR_I,
	input wire logic [LEN_W-1:0] CMD_LEN_I,
	input wire logic WR_VALID_I,
	output logic WR_READY_O,
	input wire logic [7:0] WR_DATA_I,
	output logic RD_VALID_O,
	input wire logic RD_READY_I,
	output logic [7:0] RD_DATA_O,
	output logic DONE_O,
	output logic NACK_O,
	output logic SCL_O,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_B_O
);
	import eeprom_host_pkg::*;

	localparam logic [QUARTER_W-1:0] Q_LAST = QUARTER_W'(QUARTER_LEN - 1);
	localparam logic [3:0] PULSE_LAST = 4'(RECOVER_PULSES - 1);

	state_type state_ff;
	stage_type stage_ff;
	op_type op_ff;
	logic [QUARTER_W-1:0] tick_cnt_ff;
	logic [1:0] ph_ff;
	logic [2:0] bit_ff;
	logic [3:0] pulse_ff;
	logic [7:0] shift_ff;
	logic [ADDR_W-1:0] addr_ff;
	logic [LEN_W-1:0] len_ff;
	logic [31:0] poll_cnt_ff;
	logic scl_ff;
	logic sda_oe_b_ff;
	logic sda_o_ff;
	logic cmd_ready_ff;
	logic done_ff;
	logic nack_ff;
	logic retry_ff;
	logic fail_ff;
	logic poll_on_ff;
	logic sda_s;
	logic tick;
	logic hold;
	logic adv;
	logic ack_ok;
	logic want_wdata;
	logic poll_expired;
	logic restart;
	logic finish;
	logic cmd_take;

	byte_stream_if #(.W(8)) wr_in ();
	byte_stream_if #(.W(8)) wr_out ();
	byte_stream_if #(.W(8)) rd_in ();
	byte_stream_if #(.W(8)) rd_out ();

	// device address word: type code, upper address bits, direction
	function automatic logic [7:0] dev_word(input logic [ADDR_W-1:0] a, input logic rd);
		logic [10:0] ext;
		ext = 11'(a);
		return {DEV_TYPE_CODE, ext[10:8], rd};
	endfunction

	function automatic logic [7:0] word_addr(input logic [ADDR_W-1:0] a);
		logic [10:0] ext;
		ext = 11'(a);
		return ext[7:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// pin input and data buffers

	pin_sync2 #(.W(1), .RST_VAL(SDA_RELEASED)) u_sda_sync (
		.clk_i(CLK_I),
		.rst_b_i(RST_B_I),
		.d_i(SDA_I),
		.q_o(sda_s)
	);

	skid_fifo2 #(.W(8)) u_wr_buf (
		.clk_i(CLK_I),
		.rst_b_i(RST_B_I),
		.in_s(wr_in.snk),
		.out_s(wr_out.src)
	);

	skid_fifo2 #(.W(8)) u_rd_buf (
		.clk_i(CLK_I),
		.rst_b_i(RST_B_I),
		.in_s(rd_in.snk),
		.out_s(rd_out.src)
	);

	assign wr_in.valid = WR_VALID_I;
	assign wr_in.data = WR_DATA_I;
	assign WR_READY_O = wr_in.ready;
	assign rd_out.ready = RD_READY_I;
	assign RD_VALID_O = rd_out.valid;
	assign RD_DATA_O = rd_out.data;

	////////////////////////////////////////////////////////////////////////////////
	// bit timing: four quarters per bit cell, frozen while a buffer stalls

	assign tick = tick_cnt_ff == Q_LAST;
	assign ack_ok = !sda_s;
	assign want_wdata = op_ff == OP_WRITE &&
		(stage_ff == STG_ADDR || (stage_ff == STG_WDATA && len_ff != '0));
	assign wr_out.ready = tick && state_ff == ST_ACK && ph_ff == PH_LAST && want_wdata && ack_ok;
	assign rd_in.valid = tick && state_ff == ST_BYTE && stage_ff == STG_RDATA &&
		bit_ff == BIT_LAST && ph_ff == PH_LAST;
	assign rd_in.data = {shift_ff[6:0], sda_s};
	// stalls land at the end of quarter 3, so scl is simply stretched high
	assign hold = (wr_out.ready && !wr_out.valid) || (rd_in.valid && !rd_in.ready);
	assign adv = tick && !hold;
	assign poll_expired = poll_cnt_ff >= 32'(POLL_LIMIT_CYC);
	assign restart = retry_ff && !poll_expired;
	assign finish = state_ff == ST_STOP && adv && ph_ff == PH_LAST && !restart;
	assign cmd_take = CMD_VALID_I && cmd_ready_ff;

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			tick_cnt_ff <= '0;
		end else if (state_ff == ST_IDLE || adv) begin
			tick_cnt_ff <= '0;
		end else if (!tick) begin
			tick_cnt_ff <= QUARTER_W'(tick_cnt_ff + 1'b1);
		end
	end

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			ph_ff <= 2'h0;
		end else if (state_ff == ST_IDLE) begin
			ph_ff <= 2'h0;
		end else if (adv) begin
			ph_ff <= 2'(ph_ff + 1'b1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// transfer sequencer

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			state_ff <= ST_IDLE;
			stage_ff <= STG_NONE;
			op_ff <= OP_WRITE;
			shift_ff <= 8'h00;
			bit_ff <= 3'h0;
			pulse_ff <= 4'h0;
			addr_ff <= '0;
			len_ff <= '0;
			retry_ff <= 1'b0;
			fail_ff <= 1'b0;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (cmd_take) begin
						op_ff <= op_type'(CMD_OP_I);
						addr_ff <= CMD_ADDR_I;
						len_ff <= CMD_LEN_I;
						retry_ff <= 1'b0;
						fail_ff <= 1'b0;
						pulse_ff <= 4'h0;
						stage_ff <= op_type'(CMD_OP_I) == OP_READ_CUR ? STG_DEV_R : STG_DEV_W;
						state_ff <= op_type'(CMD_OP_I) == OP_RECOVER ? ST_RECOVER : ST_START;
					end
				end
				ST_START: begin
					if (adv && ph_ff == PH_LAST) begin
						bit_ff <= 3'h0;
						if (stage_ff == STG_NONE) begin
							state_ff <= ST_STOP;
						end else begin
							state_ff <= ST_BYTE;
							shift_ff <= dev_word(addr_ff, stage_ff == STG_DEV_R);
						end
					end
				end
				ST_BYTE: begin
					if (adv && ph_ff == PH_LAST) begin
						shift_ff <= {shift_ff[6:0], sda_s};
						bit_ff <= 3'(bit_ff + 1'b1);
						if (bit_ff == BIT_LAST) begin
							state_ff <= ST_ACK;
						end
					end
				end
				ST_ACK: begin
					if (adv && ph_ff == PH_LAST) begin
						state_ff <= ST_BYTE;
						bit_ff <= 3'h0;
						case (stage_ff)
							STG_DEV_W, STG_DEV_R: begin
								if (!ack_ok) begin
									// busy programming or no match: stop and poll again
									state_ff <= ST_STOP;
									retry_ff <= 1'b1;
									stage_ff <= op_ff == OP_READ_CUR ? STG_DEV_R : STG_DEV_W;
								end else if (stage_ff == STG_DEV_R) begin
									stage_ff <= STG_RDATA;
								end else begin
									stage_ff <= STG_ADDR;
									shift_ff <= word_addr(addr_ff);
								end
							end
							STG_ADDR: begin
								if (!ack_ok) begin
									state_ff <= ST_STOP;
									fail_ff <= 1'b1;
								end else if (op_ff == OP_READ_RAND) begin
									state_ff <= ST_START;
									stage_ff <= STG_DEV_R;
								end else begin
									stage_ff <= STG_WDATA;
									shift_ff <= wr_out.data;
								end
							end
							STG_WDATA: begin
								if (!ack_ok) begin
									state_ff <= ST_STOP;
									fail_ff <= 1'b1;
								end else if (len_ff == '0) begin
									state_ff <= ST_STOP;
								end else begin
									len_ff <= LEN_W'(len_ff - 1'b1);
									shift_ff <= wr_out.data;
								end
							end
							STG_RDATA: begin
								if (len_ff == '0) begin
									state_ff <= ST_STOP;
								end else begin
									len_ff <= LEN_W'(len_ff - 1'b1);
								end
							end
							default: begin
								state_ff <= ST_STOP;
							end
						endcase
					end
				end
				ST_STOP: begin
					if (adv && ph_ff == PH_LAST) begin
						retry_ff <= 1'b0;
						// a poll that keeps failing past the write cycle time is a real error
						if (restart) begin
							state_ff <= ST_START;
						end else begin
							state_ff <= ST_IDLE;
							fail_ff <= fail_ff || retry_ff;
						end
					end
				end
				ST_RECOVER: begin
					if (adv && ph_ff == PH_LAST) begin
						pulse_ff <= 4'(pulse_ff + 1'b1);
						if (sda_s || pulse_ff == PULSE_LAST) begin
							state_ff <= ST_START;
							stage_ff <= STG_NONE;
						end
					end
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin drivers: sda moves in quarter 0 (scl low) except start and stop edges

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			scl_ff <= SCL_IDLE;
			sda_oe_b_ff <= SDA_RELEASED;
			sda_o_ff <= 1'b0;
		end else if (adv) begin
			if (ph_ff == 2'h1) begin
				scl_ff <= 1'b1;
			end
			if (ph_ff == PH_LAST && state_ff != ST_STOP) begin
				scl_ff <= 1'b0;
			end
			case (state_ff)
				ST_START: begin
					if (ph_ff == 2'h0) begin
						sda_oe_b_ff <= SDA_RELEASED;
					end else if (ph_ff == 2'h2) begin
						sda_oe_b_ff <= 1'b0;
					end
				end
				ST_BYTE: begin
					if (ph_ff == 2'h0) begin
						sda_oe_b_ff <= stage_ff == STG_RDATA ? SDA_RELEASED : shift_ff[7];
					end
				end
				ST_ACK: begin
					if (ph_ff == 2'h0) begin
						sda_oe_b_ff <= stage_ff == STG_RDATA ? len_ff == '0 : SDA_RELEASED;
					end
				end
				ST_STOP: begin
					if (ph_ff == 2'h0) begin
						sda_oe_b_ff <= 1'b0;
					end else if (ph_ff == 2'h2) begin
						sda_oe_b_ff <= SDA_RELEASED;
					end
				end
				ST_RECOVER: begin
					if (ph_ff == 2'h0) begin
						sda_oe_b_ff <= SDA_RELEASED;
					end
				end
				default: begin
					sda_oe_b_ff <= SDA_RELEASED;
				end
			endcase
		end
	end

	assign SCL_O = scl_ff;
	assign SDA_O = sda_o_ff;
	assign SDA_OE_B_O = sda_oe_b_ff;

	////////////////////////////////////////////////////////////////////////////////
	// command handshake, completion status and poll timer

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			cmd_ready_ff <= 1'b0;
			done_ff <= 1'b0;
			nack_ff <= 1'b0;
		end else begin
			cmd_ready_ff <= state_ff == ST_IDLE && !cmd_take;
			done_ff <= finish;
			if (finish) begin
				nack_ff <= fail_ff || retry_ff;
			end
		end
	end

	assign CMD_READY_O = cmd_ready_ff;
	assign DONE_O = done_ff;
	assign NACK_O = nack_ff;

	always_ff @(posedge CLK_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			poll_on_ff <= 1'b0;
			poll_cnt_ff <= 32'h0000_0000;
		end else if (state_ff == ST_IDLE) begin
			poll_on_ff <= 1'b0;
			poll_cnt_ff <= 32'h0000_0000;
		end else begin
			if (retry_ff) begin
				poll_on_ff <= 1'b1;
			end
			if ((poll_on_ff || retry_ff) && !poll_expired) begin
				poll_cnt_ff <= poll_cnt_ff + 32'h0000_0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_B_I);

	AST_START_FORM: assert property (
		state_ff == ST_START && adv && ph_ff == 2'h2 |=> scl_ff && !sda_oe_b_ff)
		else $error("start not formed with scl high");
	AST_STOP_FORM: assert property (
		state_ff == ST_STOP && adv && ph_ff == 2'h2 |=> scl_ff && sda_oe_b_ff)
		else $error("stop not formed with scl high");
	AST_DATA_SCL_LOW: assert property (
		(state_ff == ST_BYTE || state_ff == ST_ACK) && $changed(sda_oe_b_ff) |-> !scl_ff)
		else $error("data changed while scl high");
	AST_EIGHT_BITS: assert property (
		state_ff == ST_BYTE && bit_ff == BIT_LAST && adv && ph_ff == PH_LAST |=> state_ff == ST_ACK)
		else $error("ack slot not after eighth bit");
	AST_HOST_ACK: assert property (
		state_ff == ST_ACK && stage_ff == STG_RDATA && ph_ff == 2'h1 |-> sda_oe_b_ff == (len_ff == '0))
		else $error("host ack level wrong");
	AST_IDLE_BUS: assert property (
		state_ff == ST_IDLE && $past(state_ff) == ST_STOP |-> scl_ff && sda_oe_b_ff)
		else $error("bus not free after stop");
	AST_RECOVER_RELEASE: assert property (
		state_ff == ST_RECOVER && ph_ff != 2'h0 |-> sda_oe_b_ff)
		else $error("sda driven during recovery");
	AST_DEV_CODE: assert property (
		state_ff == ST_START && stage_ff != STG_NONE && adv && ph_ff == PH_LAST
		|=> shift_ff[7:4] == DEV_TYPE_CODE && {shift_ff[7:1], 1'b0} == dev_word(addr_ff, 1'b0))
		else $error("device address word malformed");
	AST_DIRECTION: assert property (
		state_ff == ST_START && stage_ff != STG_NONE && adv && ph_ff == PH_LAST
		|=> shift_ff[0] == (stage_ff == STG_DEV_R))
		else $error("direction bit wrong");
	AST_POLL_STOP: assert property (
		state_ff == ST_ACK && (stage_ff == STG_DEV_W || stage_ff == STG_DEV_R) && adv &&
		ph_ff == PH_LAST && !ack_ok |=> state_ff == ST_STOP && retry_ff)
		else $error("unacknowledged address not stopped for polling");
	AST_WRITE_STOP: assert property (
		state_ff == ST_ACK && stage_ff == STG_WDATA && adv && ph_ff == PH_LAST && ack_ok &&
		len_ff == '0 |=> state_ff == ST_STOP)
		else $error("write not ended by stop");
	AST_RAND_RESTART: assert property (
		state_ff == ST_ACK && stage_ff == STG_ADDR && op_ff == OP_READ_RAND && adv &&
		ph_ff == PH_LAST && ack_ok |=> state_ff == ST_START && stage_ff == STG_DEV_R)
		else $error("random read lacks repeated start");
	AST_SCL_HIGH_TIME: assert property (
		$rose(scl_ff) |-> scl_ff [*8])
		else $error("scl high too short");
endmodule

//--- testbench/eeprom_dev_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// behavioural serial memory on the far side of the bus; 2048 bytes, 16-byte pages
module eeprom_dev_model #(
	parameter int WR_CYC = 30000
) (
	input wire logic clk_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic mute_i,
	output logic sda_pull_b_o
);
	logic [7:0] mem [2048];
	logic [7:0] pg_d [16];
	logic [15:0] pg_v;
	logic [10:0] ptr;
	logic busy;
	logic go;
	logic hack;

	initial begin
		for (int i = 0; i < 2048; i++)
			mem[i] = 8'(i * 7 + 3);
		sda_pull_b_o = 1'b1;
		pg_v = '0;
		ptr = '0;
		busy = 1'b0;
		go = 1'b0;
		hack = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic get_byte(output logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			@(posedge scl_i);
			b = {b[6:0], sda_i};
		end
	endtask

	task automatic ack();
		@(negedge scl_i);
		#10 sda_pull_b_o = 1'b0;
		@(negedge scl_i);
		#10 sda_pull_b_o = 1'b1;
	endtask

	task automatic send_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			if (i < 7)
				@(negedge scl_i);
			#10 sda_pull_b_o = b[i];
		end
		@(negedge scl_i);
		#10 sda_pull_b_o = 1'b1;
		@(posedge scl_i);
		hack = sda_i;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// restarted from the top by every start or stop seen on the wire
	always begin : xfer
		logic [7:0] dw;
		logic [7:0] b;
		wait (go);
		go = 1'b0;
		get_byte(dw);
		if (dw[7:4] == 4'hA && !busy && !mute_i) begin
			ack();
			if (dw[0]) begin
				hack = 1'b0;
				while (!hack) begin
					send_byte(mem[ptr]);
					ptr = ptr + 11'h001;
					if (!hack)
						@(negedge scl_i);
				end
			end else begin
				get_byte(b);
				ptr = {dw[3:1], b};
				ack();
				forever begin
					get_byte(b);
					pg_d[ptr[3:0]] = b;
					pg_v[ptr[3:0]] = 1'b1;
					ptr[3:0] = ptr[3:0] + 4'h1;
					ack();
				end
			end
		end
	end

	always @(negedge sda_i) begin
		if (scl_i === 1'b1) begin
			disable xfer;
			sda_pull_b_o = 1'b1;
			pg_v = '0;
			go = 1'b1;
		end
	end

	// commit only here, so an aborted page never reaches the array
	always @(posedge sda_i) begin
		if (scl_i === 1'b1) begin
			disable xfer;
			sda_pull_b_o = 1'b1;
			for (int i = 0; i < 16; i++)
				if (pg_v[i])
					mem[{ptr[10:4], 4'(i)}] = pg_d[i];
			if (|pg_v)
				busy = 1'b1;
			pg_v = '0;
		end
	end

	always @(posedge busy) begin
		repeat (WR_CYC) @(posedge clk_i);
		busy = 1'b0;
	end
endmodule

//--- testbench/testbench.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module testbench;
	import eeprom_host_pkg::*;
	logic clk;
	logic rst_b;
	logic cmd_valid;
	logic cmd_ready;
	logic [1:0] cmd_op;
	logic [10:0] cmd_addr;
	logic [3:0] cmd_len;
	logic wr_valid;
	logic wr_ready;
	logic [7:0] wr_data;
	logic rd_valid;
	logic rd_ready;
	logic [7:0] rd_data;
	logic done;
	logic nack;
	logic scl;
	logic sda_o;
	logic sda_oe_b;
	logic dev_pull_b;
	logic dev_mute;
	logic hold_rd;
	logic done_seen;
	logic [7:0] d0;
	logic [7:0] d1;
	logic [7:0] exp_rd [$];
	logic exp_nk [$];
	int fail_count = 0;
	int n_tests = 0;
	// pull-up on the wire: released by both ends reads high
	wire sda = (sda_oe_b === 1'b0 ? sda_o : 1'b1) & dev_pull_b;

	// short quarters keep the run small; the divider is the same logic at any length
	eeprom_host_ctrl #(.POLL_LIMIT_CYC(3000), .QUARTER_LEN(16)) i_dut (
		.CLK_I(clk),
		.RST_B_I(rst_b),
		.CMD_VALID_I(cmd_valid),
		.CMD_READY_O(cmd_ready),
		.CMD_OP_I(cmd_op),
		.CMD_ADDR_I(cmd_addr),
		.CMD_LEN_I(cmd_len),
		.WR_VALID_I(wr_valid),
		.WR_READY_O(wr_ready),
		.WR_DATA_I(wr_data),
		.RD_VALID_O(rd_valid),
		.RD_READY_I(rd_ready),
		.RD_DATA_O(rd_data),
		.DONE_O(done),
		.NACK_O(nack),
		.SCL_O(scl),
		.SDA_I(sda),
		.SDA_O(sda_o),
		.SDA_OE_B_O(sda_oe_b)
	);

	// write time shorter than the poll limit, longer than the first poll
	eeprom_dev_model #(.WR_CYC(1000)) i_dev (
		.clk_i(clk),
		.scl_i(scl),
		.sda_i(sda),
		.mute_i(dev_mute),
		.sda_pull_b_o(dev_pull_b)
	);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] init_val(input int a);
		return 8'(a * 7 + 3);
	endfunction

	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic results();
		if (fail_count == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ready is looked at once settled; the edge after that takes the request
	task automatic cmd(input logic [1:0] op, input logic [10:0] a, input logic [3:0] n,
		input logic nk);
		exp_nk.push_back(nk);
		done_seen = 1'b0;
		cmd_op = op;
		cmd_addr = a;
		cmd_len = n;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1 cmd_valid = 1'b0;
		while (!done_seen) begin
			@(posedge clk);
			#1;
		end
	endtask

	task automatic push(input logic [7:0] d);
		wr_data = d;
		wr_valid = 1'b1;
		while (wr_ready !== 1'b1) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk);
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
			if (exp_rd.size() == 0)
				chk("read count", 8'h00, 8'h01);
			else
				chk("read byte", exp_rd.pop_front(), rd_data);
		end
		if (done === 1'b1) begin
			done_seen = 1'b1;
			chk("nack flag", {7'h00, exp_nk.pop_front()}, {7'h00, nack});
		end
	end

	initial begin
		clk = 1'b0;
		forever
			#4 clk = ~clk;
	end

	// consumer stalls at random, or for good while hold_rd is set
	initial begin
		forever begin
			@(posedge clk);
			#1 rd_ready = hold_rd ? 1'b0 : 1'($urandom_range(1));
		end
	end

	initial begin
		#240000;
		fail_count++;
		results();
	end

	initial begin
		void'($urandom(21236));
		rst_b = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = 2'h0;
		cmd_addr = 11'h000;
		cmd_len = 4'h0;
		wr_valid = 1'b0;
		wr_data = 8'h00;
		rd_ready = 1'b0;
		dev_mute = 1'b0;
		hold_rd = 1'b1;
		done_seen = 1'b0;
		repeat (4) @(posedge clk);
		chk("scl idle", {7'h00, SCL_IDLE}, {7'h00, scl});
		chk("sda idle", {7'h00, SDA_RELEASED}, {7'h00, sda_oe_b});
		chk("sda out level", 8'h00, {7'h00, sda_o});
		#1 rst_b = 1'b1;
		cmd(2'h3, 11'h000, 4'h0, 1'b0);
		d0 = 8'($urandom);
		d1 = 8'($urandom);
		push(d0);
		push(d1);
		wr_valid = 1'b0;
		chk("write buffer full", 8'h00, {7'h00, wr_ready});
		// last byte of the last page, the second byte wraps inside the page
		cmd(2'h0, 11'h7FF, 4'h1, 1'b0);
		exp_rd.push_back(d0);
		exp_rd.push_back(init_val(0));
		exp_rd.push_back(init_val(1));
		fork
			cmd(2'h2, 11'h7FF, 4'h2, 1'b0);
			begin
				// one more byte fills the buffer, the third then stalls with scl high
				wait (rd_valid === 1'b1);
				repeat (1300) @(posedge clk);
				#1 chk("scl held high in stall", {7'h00, SCL_IDLE}, {7'h00, scl});
				hold_rd = 1'b0;
			end
		join
		exp_rd.push_back(init_val(2));
		cmd(2'h1, 11'h000, 4'h0, 1'b0);
		// a silent target: polling gives up after its limit and reports a failure
		dev_mute = 1'b1;
		cmd(2'h1, 11'h000, 4'h0, 1'b1);
		dev_mute = 1'b0;
		// the wrapped second byte of the page write landed at the page start
		exp_rd.push_back(d1);
		cmd(2'h2, 11'h7F0, 4'h0, 1'b0);
		chk("reads left over", 8'h00, 8'(exp_rd.size()));
		results();
	end
endmodule
